/* File: mpc_pkg.sv */
package mpc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PIN_LOW = 12'h820;
  localparam logic [11:0] IDX_PIN_HIGH = 12'h821;
  localparam logic [11:0] IDX_PWR = 12'h822;
  localparam logic [11:0] IDX_AUX_EN = 12'h824;
  localparam logic [11:0] IDX_OSC = 12'h826;
  localparam logic [11:0] IDX_DAC_INIT = 12'h827;

  // Writable bits of each register; the rest read as zero
  localparam logic [31:0] MASK_PIN = 32'h00ff_ffff;
  localparam logic [31:0] MASK_PWR = 32'h0000_03ef;
  localparam logic [31:0] MASK_AUX_EN = 32'h0000_8000;
  localparam logic [31:0] MASK_OSC = 32'h0000_0004;
  localparam logic [31:0] MASK_DAC_INIT = 32'h0000_0003;

  // Reset values
  localparam logic [23:0] RST_PIN = 24'h00_0000;
  localparam logic [15:0] RST_CTL = 16'h0000;

  // Field positions
  localparam int FIELD_W = 4;
  localparam int PINS_PER_REG = 6;
  localparam int NUM_PINS = 12;
  localparam int INV_BIT = 3;
  localparam int SMOOTH_LSB = 8;
  localparam int CONV_OFF_BIT = 7;
  localparam int REFBUF_OFF_BIT = 6;
  localparam int REF_OFF_BIT = 5;
  localparam int DAC_ZERO_OFF_BIT = 3;
  localparam int AUX_ON_BIT = 15;
  localparam int OSC_OFF_BIT = 2;
  localparam int DAC_INIT_LSB = 0;

  // Pin function codes (low three bits unless noted)
  localparam logic [2:0] FN_IN_DEBOUNCE = 3'h0;
  localparam logic [2:0] FN_IN_RAW = 3'h1;
  localparam logic [2:0] FN_OUT = 3'h2;
  localparam logic [2:0] FN_OPEN_DRAIN = 3'h3;
  localparam logic [2:0] FN_SERIAL = 3'h4;
  localparam logic [2:0] FN_NONE = 3'h7;
  localparam logic [3:0] FN_AUX_IN = 4'hf;

  // Auxiliary converter smoothing modes
  localparam logic [1:0] SM_HYST4 = 2'h0;
  localparam logic [1:0] SM_HYST5 = 2'h1;
  localparam logic [1:0] SM_BYPASS_ALL = 2'h2;
  localparam logic [1:0] SM_BYPASS_LP = 2'h3;

  localparam logic [1:0] DAC_INIT_GO = 2'h1;
  localparam int AUX_RESULT_BITS = 12;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } mpc_bus_e;

  typedef struct packed {
    logic invert;
    logic pullup_on;
    logic gpio_in;
    logic debounce_on;
    logic gpio_out;
    logic open_drain;
    logic serial_port;
    logic aux_in;
    logic reserved_code;
  } mpc_pin_ctl_s;

  typedef struct packed {
    logic converters_off;
    logic ref_buffer_off;
    logic reference_off;
    logic [3:0] dac_off;
    logic aux_converter_on;
    logic [1:0] smoothing;
    logic lowpass_on;
    logic hysteresis_on;
    logic hysteresis_wide;
    logic oscillator_off;
    logic [1:0] dac_init_code;
    logic dac_init_valid;
  } mpc_power_ctl_s;

endpackage

/* File: mpc_regs.sv */
`timescale 1ns/1ps

module mpc_regs #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave, byte addressed
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Decoded pin controls
  output mpc_pkg::mpc_pin_ctl_s [mpc_pkg::NUM_PINS-1:0] pin_ctl,
  // Analog and clock controls
  output mpc_pkg::mpc_power_ctl_s power_ctl
);

  // Highest register must be reachable
  if (ADDR_W < 14) begin : g_addr_check
    $error("ADDR_W must be at least 14");
  end

  // Merge write data into a register under byte enables and a mask
  function automatic logic [31:0] merge_word(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge_word = ((old_val & ~lanes) | (new_val & lanes)) & mask;
  endfunction

  // Turn one pin field into its control signals
  function automatic mpc_pkg::mpc_pin_ctl_s decode_pin(input logic [3:0] fld);
    mpc_pkg::mpc_pin_ctl_s c;
    logic [2:0] base;
    c = '0;
    base = fld[2:0];
    c.invert = fld[mpc_pkg::INV_BIT];
    if (fld == mpc_pkg::FN_AUX_IN) begin
      c.aux_in = 1'b1;
    end else begin
      case (base)
        mpc_pkg::FN_IN_DEBOUNCE: begin
          c.gpio_in = 1'b1;
          c.debounce_on = 1'b1;
          c.pullup_on = 1'b1;
        end
        mpc_pkg::FN_IN_RAW: begin
          c.gpio_in = 1'b1;
          c.pullup_on = 1'b1;
        end
        mpc_pkg::FN_OUT: begin
          c.gpio_out = 1'b1;
        end
        mpc_pkg::FN_OPEN_DRAIN: begin
          c.gpio_out = 1'b1;
          c.open_drain = 1'b1;
        end
        mpc_pkg::FN_SERIAL: begin
          // Pin acts as serial data input or output
          c.serial_port = 1'b1;
          c.pullup_on = 1'b1;
        end
        mpc_pkg::FN_NONE: begin
          c.invert = 1'b0;
        end
        default: begin
          c.reserved_code = 1'b1;
          c.invert = 1'b0;
        end
      endcase
    end
    decode_pin = c;
  endfunction

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_sync_n = rst_sync_r;

  // Register storage
  logic [23:0] pin_low_r;
  logic [23:0] pin_high_r;
  logic [15:0] pwr_r;
  logic [15:0] aux_en_r;
  logic [15:0] osc_r;
  logic [15:0] dac_init_r;

  // Address decode
  wire addr_aligned = (avs_address[1:0] == 2'h0);
  wire [ADDR_W-3:0] word_idx = avs_address[ADDR_W-1:2];
  wire hit_pin_low = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_PIN_LOW));
  wire hit_pin_high = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_PIN_HIGH));
  wire hit_pwr = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_PWR));
  wire hit_aux_en = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_AUX_EN));
  wire hit_osc = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_OSC));
  wire hit_dac_init = addr_aligned && (word_idx == (ADDR_W-2)'(mpc_pkg::IDX_DAC_INIT));
  wire hit_any = hit_pin_low | hit_pin_high | hit_pwr | hit_aux_en | hit_osc | hit_dac_init;

  // Read selection; reserved bits come back zero
  wire [31:0] rd_word =
    hit_pin_low ? ({8'h00, pin_low_r} & mpc_pkg::MASK_PIN) :
    hit_pin_high ? ({8'h00, pin_high_r} & mpc_pkg::MASK_PIN) :
    hit_pwr ? ({16'h0000, pwr_r} & mpc_pkg::MASK_PWR) :
    hit_aux_en ? ({16'h0000, aux_en_r} & mpc_pkg::MASK_AUX_EN) :
    hit_osc ? ({16'h0000, osc_r} & mpc_pkg::MASK_OSC) :
    hit_dac_init ? ({16'h0000, dac_init_r} & mpc_pkg::MASK_DAC_INIT) :
    32'h0000_0000;

  // Bus handshake: one wait cycle, then answer for one cycle
  mpc_pkg::mpc_bus_e bus_state_r;
  mpc_pkg::mpc_bus_e bus_state_nxt;
  wire bus_req = avs_read | avs_write;
  wire bus_accept = (bus_state_r == mpc_pkg::BUS_ANSWER) && bus_req;
  wire wr_take = bus_accept && avs_write;

  always_comb begin
    case (bus_state_r)
      mpc_pkg::BUS_IDLE: bus_state_nxt = bus_req ? mpc_pkg::BUS_ANSWER : mpc_pkg::BUS_IDLE;
      mpc_pkg::BUS_ANSWER: bus_state_nxt = mpc_pkg::BUS_IDLE;
      default: bus_state_nxt = mpc_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_state_r <= mpc_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= mpc_pkg::RESP_OKAY;
    end else begin
      bus_state_r <= bus_state_nxt;
      avs_waitrequest <= !(bus_state_r == mpc_pkg::BUS_IDLE && bus_req);
      if (bus_state_r == mpc_pkg::BUS_IDLE && bus_req) begin
        avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
        avs_response <= hit_any ? mpc_pkg::RESP_OKAY : mpc_pkg::RESP_SLVERR;
      end
    end
  end

  // Next values of the registers
  wire [31:0] pin_low_nxt = merge_word({8'h00, pin_low_r}, avs_writedata, avs_byteenable, mpc_pkg::MASK_PIN);
  wire [31:0] pin_high_nxt = merge_word({8'h00, pin_high_r}, avs_writedata, avs_byteenable, mpc_pkg::MASK_PIN);
  wire [31:0] pwr_nxt = merge_word({16'h0000, pwr_r}, avs_writedata, avs_byteenable, mpc_pkg::MASK_PWR);
  wire [31:0] aux_en_nxt = merge_word({16'h0000, aux_en_r}, avs_writedata, avs_byteenable, mpc_pkg::MASK_AUX_EN);
  wire [31:0] osc_nxt = merge_word({16'h0000, osc_r}, avs_writedata, avs_byteenable, mpc_pkg::MASK_OSC);
  wire [31:0] dac_init_nxt = merge_word({16'h0000, dac_init_r}, avs_writedata, avs_byteenable,
                                        mpc_pkg::MASK_DAC_INIT);

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_low_r <= mpc_pkg::RST_PIN;
      pin_high_r <= mpc_pkg::RST_PIN;
      pwr_r <= mpc_pkg::RST_CTL;
      aux_en_r <= mpc_pkg::RST_CTL;
      osc_r <= mpc_pkg::RST_CTL;
      dac_init_r <= mpc_pkg::RST_CTL;
    end else if (wr_take) begin
      if (hit_pin_low) begin
        pin_low_r <= pin_low_nxt[23:0];
      end
      if (hit_pin_high) begin
        pin_high_r <= pin_high_nxt[23:0];
      end
      if (hit_pwr) begin
        pwr_r <= pwr_nxt[15:0];
      end
      if (hit_aux_en) begin
        aux_en_r <= aux_en_nxt[15:0];
      end
      if (hit_osc) begin
        osc_r <= osc_nxt[15:0];
      end
      if (hit_dac_init) begin
        dac_init_r <= dac_init_nxt[15:0];
      end
    end
  end

  // Pin field decode: pins 0-5 from low register, 6-11 from high
  wire [47:0] all_fields = {pin_high_r, pin_low_r};
  mpc_pkg::mpc_pin_ctl_s [mpc_pkg::NUM_PINS-1:0] pin_ctl_nxt;
  for (genvar p = 0; p < mpc_pkg::NUM_PINS; p++) begin : g_pin
    assign pin_ctl_nxt[p] = decode_pin(all_fields[p*mpc_pkg::FIELD_W +: mpc_pkg::FIELD_W]);
  end

  // Power and converter controls
  wire [1:0] smooth_sel = pwr_r[mpc_pkg::SMOOTH_LSB +: 2];
  wire aux_on = aux_en_r[mpc_pkg::AUX_ON_BIT];
  mpc_pkg::mpc_power_ctl_s power_ctl_nxt;
  assign power_ctl_nxt.converters_off = pwr_r[mpc_pkg::CONV_OFF_BIT];
  assign power_ctl_nxt.ref_buffer_off = pwr_r[mpc_pkg::REFBUF_OFF_BIT];
  assign power_ctl_nxt.reference_off = pwr_r[mpc_pkg::REF_OFF_BIT];
  // dac_off[0] is DAC0 at the top bit of the nibble
  assign power_ctl_nxt.dac_off = {pwr_r[mpc_pkg::DAC_ZERO_OFF_BIT-3], pwr_r[mpc_pkg::DAC_ZERO_OFF_BIT-2],
                                  pwr_r[mpc_pkg::DAC_ZERO_OFF_BIT-1], pwr_r[mpc_pkg::DAC_ZERO_OFF_BIT]};
  assign power_ctl_nxt.aux_converter_on = aux_on;
  assign power_ctl_nxt.smoothing = smooth_sel;
  assign power_ctl_nxt.lowpass_on = aux_on && (smooth_sel != mpc_pkg::SM_BYPASS_ALL)
                                    && (smooth_sel != mpc_pkg::SM_BYPASS_LP);
  assign power_ctl_nxt.hysteresis_on = aux_on && (smooth_sel != mpc_pkg::SM_BYPASS_ALL);
  assign power_ctl_nxt.hysteresis_wide = (smooth_sel == mpc_pkg::SM_HYST5);
  assign power_ctl_nxt.oscillator_off = osc_r[mpc_pkg::OSC_OFF_BIT];
  assign power_ctl_nxt.dac_init_code = dac_init_r[mpc_pkg::DAC_INIT_LSB +: 2];
  assign power_ctl_nxt.dac_init_valid = (dac_init_r[mpc_pkg::DAC_INIT_LSB +: 2] == mpc_pkg::DAC_INIT_GO);

  // Registered control outputs
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_ctl <= '0;
      power_ctl <= '0;
    end else begin
      pin_ctl <= pin_ctl_nxt;
      power_ctl <= power_ctl_nxt;
    end
  end

endmodule

/* File: mpc_regs_monitor.sv */
`timescale 1ns/1ps
module mpc_regs_monitor #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Controls
  input wire mpc_pkg::mpc_pin_ctl_s [mpc_pkg::NUM_PINS-1:0] pin_ctl,
  input wire mpc_pkg::mpc_power_ctl_s power_ctl
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [11:0] idx = avs_address[13:2];
  wire logic mapped = avs_address[1:0] == 2'h0 && (idx inside {12'h820, 12'h821, 12'h822, 12'h824, 12'h826, 12'h827});
  wire logic req = avs_read | avs_write;
  for (genvar i = 0; i < mpc_pkg::NUM_PINS; i++) begin : g_pin
    a_pullup_input: assert property (pin_ctl[i].pullup_on == (pin_ctl[i].gpio_in | pin_ctl[i].serial_port))
      else $error("pull-up does not follow input function");
    a_debounce_input: assert property (pin_ctl[i].debounce_on |-> pin_ctl[i].gpio_in)
      else $error("debounce on a non-input pin");
    a_single_function: assert property (
      $onehot0({pin_ctl[i].gpio_in, pin_ctl[i].gpio_out, pin_ctl[i].serial_port, pin_ctl[i].aux_in,
      pin_ctl[i].reserved_code}) && (!pin_ctl[i].open_drain || pin_ctl[i].gpio_out))
      else $error("pin holds two functions");
  end
  a_wait_one_cycle: assert property ($rose(req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not one cycle after request");
  a_answer_needs_req: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without request");
  a_unmapped_error: assert property (
    $rose(avs_read) && !mapped |=> avs_response == mpc_pkg::RESP_SLVERR && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property ($rose(req) && mapped |=> avs_response == mpc_pkg::RESP_OKAY)
    else $error("mapped access refused");
  a_lowpass_default: assert property (
    power_ctl.lowpass_on == (power_ctl.aux_converter_on && !power_ctl.smoothing[1]))
    else $error("low-pass state wrong");
  a_hysteresis_mode: assert property (
    power_ctl.hysteresis_on == (power_ctl.aux_converter_on && power_ctl.smoothing != mpc_pkg::SM_BYPASS_ALL))
    else $error("hysteresis state wrong");
  a_init_valid: assert property (
    power_ctl.dac_init_valid == (power_ctl.dac_init_code == mpc_pkg::DAC_INIT_GO))
    else $error("dac init valid wrong");
  a_osc_write_lands: assert property (
    $rose(avs_write) && mapped && idx == 12'h826 && avs_byteenable[0]
    |-> ##3 power_ctl.oscillator_off == $past(avs_writedata[2], 3))
    else $error("oscillator write not applied");
endmodule
bind mpc_regs mpc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .pin_ctl(pin_ctl), .power_ctl(power_ctl));

/* File: test_mpc_regs.sv */
`timescale 1ns/1ps
module test_mpc_regs;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, bm;
  logic [3:0] avs_byteenable, be;
  logic [1:0] avs_response, rsp;
  mpc_pkg::mpc_pin_ctl_s [mpc_pkg::NUM_PINS-1:0] pin_ctl;
  mpc_pkg::mpc_power_ctl_s power_ctl;
  int fail_count, comparisons, r;
  logic [11:0] idx_tab [6] = '{12'h820, 12'h821, 12'h822, 12'h824, 12'h826, 12'h827};
  logic [31:0] mask_tab [6] = '{32'hff_ffff, 32'hff_ffff, 32'h3ef, 32'h8000, 32'h4, 32'h3};
  logic [31:0] sh [6];
  logic [11:0] gap_tab [3] = '{12'h823, 12'h825, 12'h828};
  mpc_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .pin_ctl(pin_ctl), .power_ctl(power_ctl));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d, input logic [3:0] b);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    @(posedge core_clk);
    while (avs_waitrequest) @(posedge core_clk);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] b);
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    sh[i] = ((sh[i] & ~bm) | (d & bm)) & mask_tab[i];
    bus(1'b1, {idx_tab[i], 2'b00}, d, b);
  endtask
  function automatic mpc_pkg::mpc_pin_ctl_s pin_exp(input logic [3:0] c);
    mpc_pkg::mpc_pin_ctl_s e;
    e = '0;
    e.reserved_code = c inside {4'h5, 4'h6, 4'hd, 4'he};
    e.invert = c[3] && !e.reserved_code;
    e.gpio_in = c[2:1] == 2'h0;
    e.debounce_on = c[2:0] == 3'h0;
    e.gpio_out = c[2:1] == 2'h1;
    e.open_drain = c[2:0] == 3'h3;
    e.serial_port = c[2:0] == 3'h4;
    e.aux_in = c == 4'hf;
    e.pullup_on = e.gpio_in | e.serial_port;
    return e;
  endfunction
  function automatic mpc_pkg::mpc_power_ctl_s pwr_exp();
    mpc_pkg::mpc_power_ctl_s e;
    e.converters_off = sh[2][7];
    e.ref_buffer_off = sh[2][6];
    e.reference_off = sh[2][5];
    e.dac_off = {sh[2][0], sh[2][1], sh[2][2], sh[2][3]};
    e.aux_converter_on = sh[3][15];
    e.smoothing = sh[2][9:8];
    e.lowpass_on = sh[3][15] && !sh[2][9];
    e.hysteresis_on = sh[3][15] && sh[2][9:8] != 2'h2;
    e.hysteresis_wide = sh[2][9:8] == 2'h1;
    e.oscillator_off = sh[4][2];
    e.dac_init_code = sh[5][1:0];
    e.dac_init_valid = sh[5][1:0] == 2'h1;
    return e;
  endfunction
  task automatic check_outs();
    repeat (2) @(posedge core_clk);
    check(64'(power_ctl), 64'(pwr_exp()));
    for (int i = 0; i < 12; i++) begin
      check(64'(pin_ctl[i]), 64'(pin_exp(sh[i / 6][4 * (i % 6) +: 4])));
    end
  endtask
  task automatic check_reset();
    for (int i = 0; i < 6; i++) begin
      sh[i] = 32'h0;
      bus(1'b0, {idx_tab[i], 2'b00}, 32'h0, 4'h0);
      check(rd, 64'h0);
      check(rsp, 64'(mpc_pkg::RESP_OKAY));
    end
    check_outs();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h37bddea1));
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Reset values
    check_reset();
    // Unmapped and unaligned places
    foreach (idx_tab[i]) begin
      bus(1'b1, {idx_tab[i], 2'b00} + 14'h5, 32'hffff_ffff, 4'hf);
      bus(1'b0, {idx_tab[i], 2'b00} + 14'h5, 32'h0, 4'h0);
      check(rd, 64'h0);
      check(rsp, 64'(mpc_pkg::RESP_SLVERR));
    end
    // Aligned holes in the map
    foreach (gap_tab[i]) begin
      bus(1'b1, {gap_tab[i], 2'b00}, 32'hffff_ffff, 4'hf);
      check(rsp, 64'(mpc_pkg::RESP_SLVERR));
      bus(1'b0, {gap_tab[i], 2'b00}, 32'h0, 4'h0);
      check(rd, 64'h0);
      check(rsp, 64'(mpc_pkg::RESP_SLVERR));
    end
    // Every code on every pin
    for (int c = 0; c < 16; c++) begin
      for (int i = 0; i < 12; i++) begin
        bm[4 * (i % 6) +: 4] = 4'(c + i);
        if (i % 6 == 5) wr_reg(i / 6, {8'h0, bm[23:0]}, 4'hf);
      end
      check_outs();
    end
    // All smoothing and setup codes with converter on
    wr_reg(3, 32'h8000, 4'hf);
    for (int s = 0; s < 4; s++) begin
      wr_reg(2, 32'(s) << 8, 4'hf);
      wr_reg(5, 32'(s), 4'hf);
      check_outs();
    end
    // Random writes with partial lanes
    for (int n = 0; n < 60; n++) begin
      r = $urandom_range(5);
      be = 4'($urandom);
      wr_reg(r, $urandom, be);
      check(rsp, 64'(mpc_pkg::RESP_OKAY));
      bus(1'b0, {idx_tab[r], 2'b00}, 32'h0, 4'h0);
      check(rd, sh[r]);
      check_outs();
    end
    // Reset in mid-run clears everything again
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_reset();
    wrap_up();
  end
endmodule
